// *** logic/drive_option_defs.svh ***
// constants for the option strap decoder: offsets, fields, timing
`ifndef DRIVE_OPTION_DEFS_SVH
`define DRIVE_OPTION_DEFS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_PERIOD_NS 20
`define SEC_NS 1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)
`define SPINUP_STEP_S 12
`define SETTLE_CYCLES 2

// ****************************************************************
// register port
// ****************************************************************
`define ADDR_W 4
`define DATA_W 32
`define REG_CONFIG 4'h0
`define REG_STATUS 4'h4
`define REG_COMMAND 4'h8
`define REG_PERR_COUNT 4'hC

// ****************************************************************
// field positions
// ****************************************************************
`define CFG_STRAPS_LSB 0
`define CFG_ID_LSB 8
`define CFG_VALID_BIT 16
`define STS_LVD_BIT 0
`define STS_SPIN_LSB 1
`define STS_TIMER_BIT 3
`define CMD_START_BIT 0
`define PERR_W 16

`endif

// *** logic/drive_option_pkg.sv ***
// types shared by the option strap decoder files
package drive_option_pkg;

  typedef struct packed {
    logic unused_strap_position;
    logic parity_check_disable_strap;
    logic write_protect_strap;
    logic motor_start_on_command_strap;
    logic delayed_spinup_strap;
    logic single_ended_force_strap;
  } strap_set_s;

  typedef struct packed {
    strap_set_s straps;
    logic [3:0] bus_id;
  } drive_cfg_s;

  typedef struct packed {
    logic wide;
    logic [15:0] data;
    logic [1:0] parity;
  } bus_xfer_s;

  typedef enum logic [1:0] {
    CFG_SETTLE = 2'b00,
    CFG_CAPTURE = 2'b01,
    CFG_RUN = 2'b11
  } cfg_state_e;

  typedef enum logic [1:0] {
    SP_HOLD = 2'b00,
    SP_DELAY = 2'b01,
    SP_SPIN = 2'b11,
    SP_WAIT_CMD = 2'b10
  } spin_state_e;

endpackage

// *** logic/pin_synchronizer.sv ***
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module pin_synchronizer #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= i_async[b];
          sync_reg <= meta_reg;
        end
      end
      assign o_sync[b] = sync_reg;
    end
  endgenerate

endmodule

// *** logic/spinup_delay_timer.sv ***
// whole-second countdown used to stagger spindle start
`timescale 1ns/1ns
`include "drive_option_defs.svh"
module spinup_delay_timer #(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES,
  parameter int SECS_W = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [SECS_W-1:0] i_seconds,
  output logic o_busy,
  output logic o_done
);

  logic [31:0] div_reg;
  logic [SECS_W-1:0] left_reg;
  logic busy_reg;
  logic done_reg;

  wire sec_tick = busy_reg && (div_reg == 32'(SEC_CYCLES - 1));
  wire last_sec = sec_tick && (left_reg == SECS_W'(1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_reg <= 32'h0;
      left_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (i_start) begin
        div_reg <= 32'h0;
        left_reg <= i_seconds;
        busy_reg <= (i_seconds != '0);
        done_reg <= (i_seconds == '0);
      end else if (busy_reg) begin
        div_reg <= sec_tick ? 32'h0 : div_reg + 32'h1;
        if (sec_tick) begin
          left_reg <= left_reg - SECS_W'(1);
        end
        if (last_sec) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;

endmodule

// *** logic/drive_option_strap_decoder.sv ***
// power-on option strap decoder: bus mode, spindle start, protect, parity
`timescale 1ns/1ns
`include "drive_option_defs.svh"

module drive_option_strap_decoder
  import drive_option_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES,
  parameter bit ID_FROM_CONNECTOR = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire drive_option_pkg::strap_set_s i_option_select_header_n,
  input wire logic [3:0] i_id_select_header_n,
  input wire drive_option_pkg::strap_set_s i_connector_options_n,
  input wire logic [3:0] i_connector_id_n,
  input wire logic i_bus_mode_sense_line,
  input wire logic i_xfer_valid,
  input wire drive_option_pkg::bus_xfer_s i_xfer,
  input wire logic i_write_req,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [`DATA_W-1:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [`DATA_W-1:0] o_rd_data,
  output drive_option_pkg::drive_cfg_s o_config,
  output logic o_config_valid,
  output logic o_lvd_mode,
  output logic o_spindle_start,
  output logic o_write_grant,
  output logic o_write_refused,
  output logic o_parity_valid,
  output logic o_parity_error
);
  import drive_option_pkg::*;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  localparam int SYNC_W = 21;
  localparam int SETTLE_W = 2;

  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_sync;

  // every strap, id and sense pin goes through two flops first
  assign pins_async = {i_bus_mode_sense_line,
                       i_connector_id_n,
                       i_connector_options_n,
                       i_id_select_header_n,
                       i_option_select_header_n};

  pin_synchronizer #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  wire [5:0] hdr_opts_n = pins_sync[5:0];
  wire [3:0] hdr_id_n = pins_sync[9:6];
  wire [5:0] conn_opts_n = pins_sync[15:10];
  wire [3:0] conn_id_n = pins_sync[19:16];
  wire sense_sync = pins_sync[20];

  // ****************************************************************
  // strap decode
  // ****************************************************************
  // a fitted jumper pulls its pin low; an open one floats high through
  // the pull-up, so an absent strap reads as 0, the factory default
  wire [5:0] opts_n_sel = ID_FROM_CONNECTOR ? conn_opts_n
                                            : hdr_opts_n;
  wire [3:0] id_n_sel = ID_FROM_CONNECTOR ? conn_id_n
                                          : hdr_id_n;
  wire strap_set_s decoded_straps = strap_set_s'(~opts_n_sel);
  wire [3:0] decoded_id = ~id_n_sel;

  // the adapter owns a different id; nothing here checks for a clash
  drive_cfg_s decoded_cfg;
  assign decoded_cfg = '{straps: decoded_straps,
                         bus_id: decoded_id};

  // ****************************************************************
  // one-time capture after reset
  // ****************************************************************
  cfg_state_e cfg_state_reg;
  cfg_state_e cfg_state_next;
  logic [SETTLE_W-1:0] settle_reg;
  drive_cfg_s config_reg;
  logic cfg_valid_reg;

  wire settle_done = (settle_reg == SETTLE_W'(`SETTLE_CYCLES));

  always_comb begin
    cfg_state_next = cfg_state_reg;
    case (cfg_state_reg)
      CFG_SETTLE: begin
        if (settle_done) begin
          cfg_state_next = CFG_CAPTURE;
        end
      end
      CFG_CAPTURE: begin
        cfg_state_next = CFG_RUN;
      end
      CFG_RUN: begin
        cfg_state_next = CFG_RUN;
      end
      default: begin
        cfg_state_next = CFG_SETTLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_state_reg <= CFG_SETTLE;
      settle_reg <= '0;
    end else begin
      cfg_state_reg <= cfg_state_next;
      if (!settle_done) begin
        settle_reg <= settle_reg + SETTLE_W'(1);
      end
    end
  end

  // the synchroniser needs two edges after release to hold real pin levels
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      config_reg <= '0;
      cfg_valid_reg <= 1'b0;
    end else if (cfg_state_reg == CFG_CAPTURE) begin
      config_reg <= decoded_cfg;
      cfg_valid_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // bus transceiver mode
  // ****************************************************************
  // sense high selects low voltage differential; before capture we stay
  // single-ended since that mode cannot harm either kind of bus
  wire lvd_next = cfg_valid_reg
                  && !config_reg.straps.single_ended_force_strap
                  && sense_sync;
  logic lvd_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lvd_reg <= 1'b0;
    end else begin
      lvd_reg <= lvd_next;
    end
  end

  // ****************************************************************
  // spindle start policy
  // ****************************************************************
  spin_state_e spin_state_reg;
  spin_state_e spin_state_next;
  logic timer_busy;
  logic timer_done;

  wire cmd_hit = i_wr_stb && (i_addr == `REG_COMMAND);
  wire start_cmd = cmd_hit && i_wr_data[`CMD_START_BIT];
  wire want_cmd = config_reg.straps.motor_start_on_command_strap;
  wire want_delay = config_reg.straps.delayed_spinup_strap && !want_cmd;
  wire [7:0] delay_secs = 8'(config_reg.bus_id * `SPINUP_STEP_S);
  wire decide = (spin_state_reg == SP_HOLD) && cfg_valid_reg;
  wire timer_start = decide && want_delay;

  always_comb begin
    spin_state_next = spin_state_reg;
    case (spin_state_reg)
      SP_HOLD: begin
        if (cfg_valid_reg) begin
          if (want_cmd) begin
            spin_state_next = SP_WAIT_CMD;
          end else if (want_delay) begin
            spin_state_next = SP_DELAY;
          end else begin
            spin_state_next = SP_SPIN;
          end
        end
      end
      SP_DELAY: begin
        if (timer_done) begin
          spin_state_next = SP_SPIN;
        end
      end
      SP_WAIT_CMD: begin
        if (start_cmd) begin
          spin_state_next = SP_SPIN;
        end
      end
      SP_SPIN: begin
        spin_state_next = SP_SPIN;
      end
      default: begin
        spin_state_next = SP_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      spin_state_reg <= SP_HOLD;
    end else begin
      spin_state_reg <= spin_state_next;
    end
  end

  // id zero gives a zero count and the timer finishes on the next edge
  spinup_delay_timer #(
    .SEC_CYCLES(SEC_CYCLES),
    .SECS_W(8)
  ) u_spin_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(timer_start),
    .i_seconds(delay_secs),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  // ****************************************************************
  // write protection
  // ****************************************************************
  // requests before the straps are known are refused, erring safe
  wire wp_block = !cfg_valid_reg
                  || config_reg.straps.write_protect_strap;
  logic write_grant_reg;
  logic write_refused_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      write_grant_reg <= 1'b0;
      write_refused_reg <= 1'b0;
    end else begin
      write_grant_reg <= i_write_req && !wp_block;
      write_refused_reg <= i_write_req && wp_block;
    end
  end

  // ****************************************************************
  // bus parity check
  // ****************************************************************
  // odd parity per byte; the upper lane counts only on wide transfers
  logic [1:0] lane_bad;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      wire lane_used = (g == 0) || i_xfer.wide;
      assign lane_bad[g] = lane_used
                           && !(^{i_xfer.data[8*g +: 8], i_xfer.parity[g]});
    end
  endgenerate

  wire check_on = cfg_valid_reg
                  && !config_reg.straps.parity_check_disable_strap;
  wire check_now = i_xfer_valid && check_on;
  wire check_bad = check_now && (lane_bad != 2'b00);
  logic parity_valid_reg;
  logic parity_error_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      parity_valid_reg <= 1'b0;
      parity_error_reg <= 1'b0;
    end else begin
      parity_valid_reg <= check_now;
      parity_error_reg <= check_bad;
    end
  end

  // ****************************************************************
  // error counter, cleared by a write; a new error beats the clear
  // ****************************************************************
  logic [`PERR_W-1:0] perr_count_reg;
  wire perr_clear = i_wr_stb && (i_addr == `REG_PERR_COUNT);
  wire perr_full = &perr_count_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      perr_count_reg <= '0;
    end else if (check_bad && perr_clear) begin
      perr_count_reg <= `PERR_W'(1);
    end else if (perr_clear) begin
      perr_count_reg <= '0;
    end else if (check_bad && !perr_full) begin
      perr_count_reg <= perr_count_reg + `PERR_W'(1);
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  wire [`DATA_W-1:0] config_word =
    (`DATA_W'(config_reg.straps) << `CFG_STRAPS_LSB)
    | (`DATA_W'(config_reg.bus_id) << `CFG_ID_LSB)
    | (`DATA_W'(cfg_valid_reg) << `CFG_VALID_BIT);
  wire [`DATA_W-1:0] status_word =
    (`DATA_W'(lvd_reg) << `STS_LVD_BIT)
    | (`DATA_W'(spin_state_reg) << `STS_SPIN_LSB)
    | (`DATA_W'(timer_busy) << `STS_TIMER_BIT);
  wire [`DATA_W-1:0] perr_word = `DATA_W'(perr_count_reg);

  // command is write-only and unmapped words read as zero
  wire [`DATA_W-1:0] rd_word =
    (i_addr == `REG_CONFIG) ? config_word :
    (i_addr == `REG_STATUS) ? status_word :
    (i_addr == `REG_PERR_COUNT) ? perr_word : `DATA_W'(0);

  logic [`DATA_W-1:0] rd_data_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= i_rd_stb ? rd_word : `DATA_W'(0);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_rd_data = rd_data_reg;
  assign o_config = config_reg;
  assign o_config_valid = cfg_valid_reg;
  assign o_lvd_mode = lvd_reg;
  assign o_spindle_start = (spin_state_reg == SP_SPIN);
  assign o_write_grant = write_grant_reg;
  assign o_write_refused = write_refused_reg;
  assign o_parity_valid = parity_valid_reg;
  assign o_parity_error = parity_error_reg;

endmodule

// *** verif/drive_option_strap_checker.sv ***
// port assertions for the option strap decoder
`timescale 1ns/1ns
`include "drive_option_defs.svh"
module drive_option_strap_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire drive_option_pkg::strap_set_s i_option_select_header_n,
  input wire logic [3:0] i_id_select_header_n,
  input wire drive_option_pkg::strap_set_s i_connector_options_n,
  input wire logic [3:0] i_connector_id_n,
  input wire logic i_bus_mode_sense_line,
  input wire logic i_xfer_valid,
  input wire drive_option_pkg::bus_xfer_s i_xfer,
  input wire logic i_write_req,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic [`DATA_W-1:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [`DATA_W-1:0] o_rd_data,
  input wire drive_option_pkg::drive_cfg_s o_config,
  input wire logic o_config_valid,
  input wire logic o_lvd_mode,
  input wire logic o_spindle_start,
  input wire logic o_write_grant,
  input wire logic o_write_refused,
  input wire logic o_parity_valid,
  input wire logic o_parity_error
);
  import drive_option_pkg::*;
  // ****************************************************************
  // helpers and checks
  // ****************************************************************
  wire strap_set_s fit = o_config.straps;
  wire cmd_wr = i_wr_stb && (i_addr == `REG_COMMAND) && i_wr_data[0];
  // a narrow transfer must never be judged on its idle upper byte
  wire bad = ~^{i_xfer.data[7:0], i_xfer.parity[0]} |
    (i_xfer.wide & ~^{i_xfer.data[15:8], i_xfer.parity[1]});
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_cfg_hold;
    o_config_valid |=> $stable(o_config);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config moved");
  // the sense line is a live bus level: two sync flops plus the mode flop
  property p_lvd_sense;
    o_config_valid && $past(o_config_valid) && !fit.single_ended_force_strap
      |-> o_lvd_mode == $past(i_bus_mode_sense_line, 3);
  endproperty
  a_lvd_sense: assert property (p_lvd_sense)
    else $error("lvd not following sense");
  property p_valid_hold; o_config_valid |=> o_config_valid; endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("valid lost");
  property p_se_force;
    o_config_valid && fit.single_ended_force_strap |-> !o_lvd_mode;
  endproperty
  a_se_force: assert property (p_se_force)
    else $error("lvd forced");
  property p_spin_now;
    $rose(o_config_valid) && !fit.delayed_spinup_strap &&
      !fit.motor_start_on_command_strap |-> ##[0:2] o_spindle_start;
  endproperty
  a_spin_now: assert property (p_spin_now)
    else $error("no spin");
  property p_spin_cmd;
    o_config_valid && fit.motor_start_on_command_strap && !cmd_wr &&
      !o_spindle_start |=> !o_spindle_start;
  endproperty
  a_spin_cmd: assert property (p_spin_cmd)
    else $error("early spin");
  property p_spin_keep; o_spindle_start |=> o_spindle_start; endproperty
  a_spin_keep: assert property (p_spin_keep)
    else $error("spin drop");
  property p_spin_delay;
    $rose(o_config_valid) && fit.delayed_spinup_strap && o_config.bus_id != 0
      |=> !o_spindle_start [*8];
  endproperty
  a_spin_delay: assert property (p_spin_delay)
    else $error("no delay");
  property p_wp;
    i_write_req && o_config_valid && fit.write_protect_strap
      |=> o_write_refused;
  endproperty
  a_wp: assert property (p_wp)
    else $error("write not refused");
  property p_wr_one;
    i_write_req |=> o_write_grant != o_write_refused;
  endproperty
  a_wr_one: assert property (p_wr_one)
    else $error("write answer");
  property p_par_off;
    fit.parity_check_disable_strap |-> !o_parity_valid && !o_parity_error;
  endproperty
  a_par_off: assert property (p_par_off)
    else $error("parity on");
  property p_par_on;
    i_xfer_valid && o_config_valid && !fit.parity_check_disable_strap
      |=> o_parity_valid;
  endproperty
  a_par_on: assert property (p_par_on)
    else $error("parity off");
  property p_par_err;
    o_parity_valid |-> o_parity_error == $past(bad);
  endproperty
  a_par_err: assert property (p_par_err)
    else $error("parity result");
endmodule
bind drive_option_strap_decoder drive_option_strap_checker chk_u (
  .i_clk, .i_sys_rst, .i_option_select_header_n, .i_id_select_header_n,
  .i_connector_options_n, .i_connector_id_n, .i_bus_mode_sense_line,
  .i_xfer_valid, .i_xfer, .i_write_req, .i_addr, .i_wr_data, .i_wr_stb,
  .i_rd_stb, .o_rd_data, .o_config, .o_config_valid, .o_lvd_mode,
  .o_spindle_start, .o_write_grant, .o_write_refused, .o_parity_valid,
  .o_parity_error
);

// *** verif/host_adapter_model.sv ***
// host adapter model: connector options, id and bus transfers
`timescale 1ns/1ns
module host_adapter_model (
  input wire logic i_clk,
  input wire drive_option_pkg::strap_set_s i_opts,
  input wire logic [3:0] i_id,
  input wire logic i_send,
  input wire drive_option_pkg::bus_xfer_s i_frame,
  output drive_option_pkg::strap_set_s o_connector_options_n,
  output logic [3:0] o_connector_id_n,
  output logic o_xfer_valid,
  output drive_option_pkg::bus_xfer_s o_xfer,
  output logic o_id_clash
);
  import drive_option_pkg::*;
  localparam logic [3:0] HOST_ID = 4'h7;
  // connector lines are active low: a selected option pulls low
  assign o_connector_options_n = ~i_opts;
  assign o_connector_id_n = ~i_id;
  assign o_id_clash = (i_id == HOST_ID);
  initial o_xfer_valid = 1'b0;
  initial o_xfer = '0;
  always @(posedge i_clk) begin
    o_xfer_valid <= i_send;
    // idle data toggles so a stale frame never looks like a fresh one
    o_xfer <= i_send ? i_frame : ~o_xfer;
  end
endmodule

// *** verif/drive_option_strap_decoder_tb_top.sv ***
// self-checking bench for the option strap decoder
`timescale 1ns/1ns
`include "drive_option_defs.svh"
module drive_option_strap_decoder_tb_top;
  import drive_option_pkg::*;
  localparam int unsigned SEC_CYC = 10;
  logic i_clk, i_sys_rst, i_bus_mode_sense_line, i_write_req;
  logic i_wr_stb, i_rd_stb, send, i_xfer_valid, id_clash;
  strap_set_s i_option_select_header_n, opts, i_connector_options_n;
  logic [3:0] i_id_select_header_n, drive_id, i_connector_id_n;
  logic [`ADDR_W-1:0] i_addr;
  logic [`DATA_W-1:0] i_wr_data, o_rd_data;
  bus_xfer_s frame, i_xfer;
  drive_cfg_s o_config;
  logic o_config_valid, o_lvd_mode, o_spindle_start, o_write_grant;
  logic o_write_refused, o_parity_valid, o_parity_error;
  int err_total;
  int samples_checked;
  host_adapter_model host_u (
    .i_clk, .i_opts(opts), .i_id(drive_id), .i_send(send), .i_frame(frame),
    .o_connector_options_n(i_connector_options_n),
    .o_connector_id_n(i_connector_id_n), .o_xfer_valid(i_xfer_valid),
    .o_xfer(i_xfer), .o_id_clash(id_clash)
  );
  drive_option_strap_decoder #(
    .SEC_CYCLES(SEC_CYC), .ID_FROM_CONNECTOR(1'b1)
  ) dut_u (
    .i_clk, .i_sys_rst, .i_option_select_header_n, .i_id_select_header_n,
    .i_connector_options_n, .i_connector_id_n, .i_bus_mode_sense_line,
    .i_xfer_valid, .i_xfer, .i_write_req, .i_addr, .i_wr_data, .i_wr_stb,
    .i_rd_stb, .o_rd_data, .o_config, .o_config_valid, .o_lvd_mode,
    .o_spindle_start, .o_write_grant, .o_write_refused, .o_parity_valid,
    .o_parity_error
  );
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // headers carry the inverse of the connector so a wrong source shows up
  task automatic power_up(input strap_set_s f, input logic [3:0] id, s);
    int n;
    @(posedge i_clk);
    opts <= f;
    drive_id <= id;
    i_option_select_header_n <= f;
    i_id_select_header_n <= id;
    i_bus_mode_sense_line <= s;
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    n = 0;
    while (o_config_valid !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    #1 check(o_config_valid, 1'b1, "config valid");
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_clk);
    i_wr_stb <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e,
                        input string what);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_clk);
    i_rd_stb <= 1'b0;
    #1 check(o_rd_data, e, what);
  endtask
  task automatic wreq(input logic g);
    @(posedge i_clk);
    i_write_req <= 1'b1;
    @(posedge i_clk);
    i_write_req <= 1'b0;
    #1 check({o_write_grant, o_write_refused}, {g, ~g}, "write answer");
  endtask
  task automatic xfer(input logic w, input logic [15:0] d,
                      input logic [1:0] p, e);
    @(posedge i_clk);
    send <= 1'b1;
    frame <= {w, d, p};
    @(posedge i_clk);
    send <= 1'b0;
    @(posedge i_clk);
    #1 check({o_parity_valid, o_parity_error}, e, "parity");
  endtask
  task automatic spin_is(input int cyc, input logic e);
    repeat (cyc) @(posedge i_clk);
    #1 check(o_spindle_start, e, "spindle");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    i_sys_rst = 1'b1;
    {i_option_select_header_n, i_id_select_header_n} = '1;
    {i_bus_mode_sense_line, i_write_req, i_wr_stb, i_rd_stb, send} = '0;
    {i_addr, i_wr_data, opts, drive_id, frame} = '0;
    err_total = 0;
    samples_checked = 0;
    power_up(6'h00, 4'h3, 1'b1);
    check(o_config, {6'h00, 4'h3}, "defaults");
    check(o_lvd_mode, 1'b1, "sense high");
    check(id_clash, 1'b0, "id clash");
    spin_is(2, 1'b1);
    reg_rd(`REG_CONFIG, 32'h0001_0300, "config reg");
    reg_rd(`REG_STATUS, 32'h0000_0007, "status");
    reg_rd(4'h2, 32'h0000_0000, "unmapped");
    wreq(1'b1);
    xfer(1'b0, 16'h0001, 2'h0, 2'h2);
    xfer(1'b0, 16'h0003, 2'h0, 2'h3);
    xfer(1'b1, 16'h0301, 2'h0, 2'h3);
    xfer(1'b0, 16'h0301, 2'h0, 2'h2);
    xfer(1'b1, 16'h0201, 2'h0, 2'h2);
    reg_rd(`REG_PERR_COUNT, 32'h0000_0002, "error count");
    reg_wr(`REG_PERR_COUNT, 32'h0000_0000);
    reg_rd(`REG_PERR_COUNT, 32'h0000_0000, "count clear");
    @(posedge i_clk);
    opts <= 6'h1F;
    i_option_select_header_n <= 6'h00;
    i_bus_mode_sense_line <= 1'b0;
    repeat (10) @(posedge i_clk);
    // the sense line is a live bus level, so the mode follows it down
    #1 check({o_config, o_lvd_mode}, {6'h00, 4'h3, 1'b0}, "late");
    check(o_spindle_start, 1'b1, "late spin");
    $display("test defaults done");
    for (int k = 0; k < 3; k++) begin
      power_up({5'h00, k != 1}, 4'h1, k == 0);
      check(o_lvd_mode, 1'b0, "single ended");
    end
    $display("test bus mode done");
    power_up(6'h04, 4'h1, 1'b1);
    spin_is(30, 1'b0);
    reg_rd(`REG_STATUS, 32'h0000_0005, "wait cmd");
    reg_wr(`REG_COMMAND, 32'h0000_0001);
    spin_is(0, 1'b1);
    $display("test command start done");
    power_up(6'h02, 4'h2, 1'b1);
    reg_rd(`REG_STATUS, 32'h0000_000B, "delay");
    reg_wr(`REG_COMMAND, 32'h0000_0001);
    spin_is(230, 1'b0);
    spin_is(20, 1'b1);
    power_up(6'h02, 4'h0, 1'b1);
    spin_is(4, 1'b1);
    $display("test staggered start done");
    power_up(6'h06, 4'h1, 1'b1);
    spin_is(150, 1'b0);
    reg_wr(`REG_COMMAND, 32'h0000_0001);
    spin_is(0, 1'b1);
    $display("test both straps done");
    power_up(6'h18, 4'h5, 1'b1);
    check(o_config, {6'h18, 4'h5}, "protect config");
    wreq(1'b0);
    xfer(1'b0, 16'h0003, 2'h0, 2'h0);
    reg_rd(`REG_PERR_COUNT, 32'h0000_0000, "no count");
    $display("test protect and parity done");
    summarize();
  end
  // the tests need under 1500 cycles; this leaves a wide margin
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    summarize();
  end
endmodule
